// File: rcb_pkg.sv
// Package with widths and timing counts for the registered command buffer
package rcb_pkg;
	localparam int unsigned GATED_W = 22;
	localparam int unsigned CKE_W = 2;
	localparam int unsigned ODT_W = 2;
	localparam int unsigned CS_W = 4;
	localparam int unsigned FIFO_W = 23;
	localparam int unsigned FIFO_D = 16;
	localparam logic [1:0] ERR_HOLD_CYC = 2'h2;
	localparam logic [1:0] RST_QUIET_CYC = 2'h3;
	localparam logic [GATED_W-1:0] GATED_RST = 22'h000000;
	localparam logic [1:0] PAIR_RST = 2'h0;
endpackage

// File: rcb_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
module rcb_fifo #(
	parameter int unsigned W = 23,
	parameter int unsigned D = 16,
	parameter int unsigned AW = $clog2(D)
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Handshakes on both sides
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_ready = (count != (AW+1)'(D));
	assign o_valid = (count != '0);
	assign o_data = mem[rd_ptr];

	// Storage write
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// File: rcb_buffer.sv
// Registered 1:2 command buffer with chip-select gating and parity check
`timescale 1ns/100ps
module rcb_buffer (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [rcb_pkg::GATED_W-1:0] i_gated_data_in,
	input wire logic i_chip_select_in0_n,
	input wire logic i_chip_select_in1_n,
	input wire logic i_chip_select_in2_n,
	input wire logic i_chip_select_in3_n,
	input wire logic i_select_gating_enable,
	input wire logic [rcb_pkg::CKE_W-1:0] i_clk_en_in,
	input wire logic [rcb_pkg::ODT_W-1:0] i_term_ctrl_in,
	input wire logic i_parity_bit_in,
	output logic [rcb_pkg::GATED_W-1:0] o_gated_data_out_a,
	output logic [rcb_pkg::GATED_W-1:0] o_gated_data_out_b,
	output logic [1:0] o_select_copy_out0_n,
	output logic [1:0] o_select_copy_out1_n,
	output logic [rcb_pkg::CKE_W-1:0] o_clk_en_out_a,
	output logic [rcb_pkg::CKE_W-1:0] o_clk_en_out_b,
	output logic [rcb_pkg::ODT_W-1:0] o_term_ctrl_out_a,
	output logic [rcb_pkg::ODT_W-1:0] o_term_ctrl_out_b,
	output logic o_parity_fault_n_out,
	output logic o_parity_fault_n_oe,
	output logic o_fifo_valid,
	input wire logic i_fifo_ready,
	output logic [rcb_pkg::FIFO_W-1:0] o_fifo_data,
	output logic o_fifo_in_stall
);
	logic any_sel;
	logic load_gated;
	logic [rcb_pkg::GATED_W-1:0] gated_q;
	logic par_data;
	logic par_valid;
	logic err_stage;
	logic [1:0] err_cnt;
	logic [1:0] quiet_cnt;
	logic next_err;
	logic fifo_ready_in;
	logic [rcb_pkg::FIFO_W-1:0] fifo_out_data;
	logic fifo_out_valid;

	// Select decode, all four selects take part
	assign any_sel = !(i_chip_select_in0_n && i_chip_select_in1_n
		&& i_chip_select_in2_n && i_chip_select_in3_n);
	assign load_gated = any_sel || !i_select_gating_enable;

	// Gated address and command register, two copies
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gated_q <= rcb_pkg::GATED_RST;
			o_gated_data_out_a <= rcb_pkg::GATED_RST;
			o_gated_data_out_b <= rcb_pkg::GATED_RST;
		end else if (load_gated) begin
			gated_q <= i_gated_data_in;
			o_gated_data_out_a <= i_gated_data_in;
			o_gated_data_out_b <= i_gated_data_in;
		end
	end

	// Ungated re-drive of selects 0 and 1, clock enables and termination
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_select_copy_out0_n <= rcb_pkg::PAIR_RST;
			o_select_copy_out1_n <= rcb_pkg::PAIR_RST;
			o_clk_en_out_a <= '0;
			o_clk_en_out_b <= '0;
			o_term_ctrl_out_a <= '0;
			o_term_ctrl_out_b <= '0;
		end else begin
			o_select_copy_out0_n <= {2{i_chip_select_in0_n}};
			o_select_copy_out1_n <= {2{i_chip_select_in1_n}};
			o_clk_en_out_a <= i_clk_en_in;
			o_clk_en_out_b <= i_clk_en_in;
			o_term_ctrl_out_a <= i_term_ctrl_in;
			o_term_ctrl_out_b <= i_term_ctrl_in;
		end
	end

	// Parity of sampled data with select-valid flag, registered so it lines up with the late parity bit
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			par_data <= 1'b0;
			par_valid <= 1'b0;
		end else begin
			par_data <= ^i_gated_data_in;
			par_valid <= any_sel;
		end
	end

	// Compare stage: data parity against the late parity bit
	assign next_err = par_valid && (par_data ^ i_parity_bit_in);

	// Error stage delays report one more cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			err_stage <= 1'b0;
		end else begin
			err_stage <= next_err;
		end
	end

	// Quiet window after reset release
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			quiet_cnt <= rcb_pkg::RST_QUIET_CYC;
		end else if (quiet_cnt != 2'h0) begin
			quiet_cnt <= quiet_cnt - 2'h1;
		end
	end

	// Fault output hold counter and open-drain driver
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			err_cnt <= 2'h0;
			o_parity_fault_n_oe <= 1'b0;
		end else if (err_cnt > 2'h1) begin
			err_cnt <= err_cnt - 2'h1;
		end else if (err_cnt == 2'h1 && !err_stage) begin
			err_cnt <= 2'h0;
			o_parity_fault_n_oe <= 1'b0;
		end else if (err_stage && quiet_cnt == 2'h0) begin
			err_cnt <= rcb_pkg::ERR_HOLD_CYC;
			o_parity_fault_n_oe <= 1'b1;
		end else if (err_cnt == 2'h1) begin
			err_cnt <= 2'h0;
			o_parity_fault_n_oe <= 1'b0;
		end
	end

	// Open drain only ever pulls low
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_parity_fault_n_out <= 1'b0;
		end else begin
			o_parity_fault_n_out <= 1'b0;
		end
	end

	// Trace FIFO of re-driven gated words with their check result
	rcb_fifo #(
		.W(rcb_pkg::FIFO_W),
		.D(rcb_pkg::FIFO_D)
	) u_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_valid(load_gated),
		.o_ready(fifo_ready_in),
		.i_data({next_err, gated_q}),
		.o_valid(fifo_out_valid),
		.i_ready(i_fifo_ready),
		.o_data(fifo_out_data)
	);

	// Registered FIFO outputs and stall flag
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fifo_valid <= 1'b0;
			o_fifo_data <= '0;
			o_fifo_in_stall <= 1'b0;
		end else begin
			o_fifo_valid <= fifo_out_valid && i_fifo_ready;
			o_fifo_data <= fifo_out_data;
			o_fifo_in_stall <= !fifo_ready_in;
		end
	end

	// Checks
	sequence s_err_seen;
		err_stage && quiet_cnt == 2'h0 && !o_parity_fault_n_oe;
	endsequence

	a_gate_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!load_gated |=> $stable(o_gated_data_out_a))
		else $error("gated data changed with all selects high");
	a_gate_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
		load_gated |=> o_gated_data_out_a == $past(i_gated_data_in))
		else $error("gated data not loaded");
	a_nogate_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_select_gating_enable |=> o_gated_data_out_b == $past(i_gated_data_in))
		else $error("ungated mode did not load");
	a_copy_equal: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_gated_data_out_a == o_gated_data_out_b)
		else $error("output copies differ");
	a_cke_redrive: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_clk_en_out_a == $past(i_clk_en_in)
		&& o_select_copy_out1_n[0] == $past(i_chip_select_in1_n))
		else $error("ungated line not re-driven");
	a_fault_delay: assert property (@(posedge i_clk) disable iff (!i_nrst)
		any_sel ##1 (i_parity_bit_in != $past(^i_gated_data_in)) ##1 s_err_seen
		|=> o_parity_fault_n_oe)
		else $error("parity fault not raised");
	a_fault_two: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_parity_fault_n_oe) |=> o_parity_fault_n_oe)
		else $error("fault shorter than two cycles");
	a_no_sel_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!any_sel |=> ##1 !err_stage)
		else $error("parity checked without select");
	a_quiet_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(i_nrst) |-> !o_parity_fault_n_oe [*3])
		else $error("fault during quiet window");
	a_never_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_parity_fault_n_out)
		else $error("open drain drove high");

	// Second copy holds while deselected
	a_hold_copy_b: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!load_gated |=> $stable(o_gated_data_out_b))
		else $error("copy b changed with all selects high");

	// Second copy loads on a select
	a_load_copy_b: assert property (@(posedge i_clk) disable iff (!i_nrst)
		load_gated |=> o_gated_data_out_b == $past(i_gated_data_in))
		else $error("copy b not loaded");

	// Select 0 copies follow the input every edge
	a_cs0_redrive: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_select_copy_out0_n == {2{$past(i_chip_select_in0_n)}})
		else $error("select 0 not re-driven");

	// Select 1 copies follow the input every edge
	a_cs1_redrive: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_select_copy_out1_n == {2{$past(i_chip_select_in1_n)}})
		else $error("select 1 not re-driven");

	// Both select 0 copies agree
	a_cs0_pair: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_select_copy_out0_n[0] == o_select_copy_out0_n[1])
		else $error("select 0 copies differ");

	// Both select 1 copies agree
	a_cs1_pair: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_select_copy_out1_n[0] == o_select_copy_out1_n[1])
		else $error("select 1 copies differ");

	// Clock enable copies agree
	a_cke_pair: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_clk_en_out_a == o_clk_en_out_b)
		else $error("clock enable copies differ");

	// Termination copies agree
	a_odt_pair: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_term_ctrl_out_a == o_term_ctrl_out_b)
		else $error("termination copies differ");

	// Termination re-driven on every edge
	a_odt_redrive: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_term_ctrl_out_a == $past(i_term_ctrl_in))
		else $error("termination not re-driven");

	// Second clock enable copy re-driven on every edge
	a_cke_copy_b: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_clk_en_out_b == $past(i_clk_en_in))
		else $error("clock enable copy b not re-driven");

	// Internal gated word matches the outputs
	a_gated_shadow: assert property (@(posedge i_clk) disable iff (!i_nrst)
		gated_q == o_gated_data_out_a)
		else $error("gated register and output differ");

	// Data parity pipelined one cycle
	a_par_pipe: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> par_data == $past(^i_gated_data_in))
		else $error("data parity not pipelined");

	// Select-valid flag ignores the gating enable
	a_par_valid: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> par_valid == $past(any_sel))
		else $error("select valid flag wrong");

	// Compare result delayed one stage
	a_err_stage: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> err_stage == $past(next_err))
		else $error("error stage not delayed");

	// A fault only rises after a compare mismatch
	a_fault_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_parity_fault_n_oe) |-> $past(err_stage))
		else $error("fault raised without mismatch");

	// Fault released once the hold count runs out
	a_fault_ends: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_parity_fault_n_oe && err_cnt == 2'h1 && !err_stage |=> !o_parity_fault_n_oe)
		else $error("fault not released");

	// Fault stays pulled while count is high
	a_fault_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
		err_cnt > 2'h1 |=> o_parity_fault_n_oe)
		else $error("fault dropped early");

	// No fault may start inside the quiet window
	a_quiet_block: assert property (@(posedge i_clk) disable iff (!i_nrst)
		quiet_cnt != 2'h0 && !o_parity_fault_n_oe |=> !o_parity_fault_n_oe)
		else $error("fault inside quiet window");

	// Quiet window counts down by one
	a_quiet_count: assert property (@(posedge i_clk) disable iff (!i_nrst)
		quiet_cnt != 2'h0 |=> quiet_cnt == $past(quiet_cnt) - 2'h1)
		else $error("quiet counter skipped");

	// Stall flag mirrors a full buffer
	a_stall_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_fifo_in_stall == !$past(fifo_ready_in))
		else $error("stall flag wrong");

	// Pop pulse only on a real handshake
	a_pop_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_fifo_valid == ($past(fifo_out_valid) && $past(i_fifo_ready)))
		else $error("pop pulse wrong");

	// Popped word shown one cycle later
	a_pop_data: assert property (@(posedge i_clk) disable iff (!i_nrst)
		1'b1 |=> o_fifo_data == $past(fifo_out_data))
		else $error("popped word wrong");
endmodule

// File: rcb_ctrl_model.sv
// Memory controller model driving command, address and parity
`timescale 1ns/100ps
module rcb_ctrl_model (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [21:0] i_d,
	input wire logic [3:0] i_cs_n,
	input wire logic i_gate,
	input wire logic [1:0] i_side,
	input wire logic i_bad,
	output logic [21:0] o_d,
	output logic [3:0] o_cs_n,
	output logic o_gate,
	output logic [1:0] o_cke,
	output logic [1:0] o_odt,
	output logic o_par
);
	logic par;
	// Every line defined; data held low while reset is active
	assign o_d = i_nrst ? i_d : 22'h000000;
	assign o_cs_n = i_nrst ? i_cs_n : 4'h0;
	assign o_gate = i_gate;
	assign o_cke = i_nrst ? i_side : 2'h0;
	assign o_odt = i_nrst ? ~i_side : 2'h0;
	assign o_par = par;
	// Parity of the word just taken, shown one cycle late; i_bad flips it
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) par <= 1'b0;
		else par <= ^i_d ^ i_bad;
	end
endmodule

// File: tb_rcb_buffer.sv
// Testbench for the registered command buffer
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_rcb_buffer;
	localparam logic [5:0][21:0] RD = {22'h2aaaaa, 22'h3fffff, 22'h00000f,
		22'h000007, 22'h000003, 22'h000001};
	localparam logic [5:0][3:0] RC = {4'hf, 4'hf, 4'h7, 4'hb, 4'hd, 4'he};
	localparam logic [5:0] RG = 6'b011011;
	localparam logic [5:0] RB = 6'b110110;
	localparam logic [5:0] RE = 6'b000110;
	localparam logic [5:0] RL = 6'b101111;
	logic i_clk, i_nrst, m_gate, m_bad, i_fifo_ready;
	logic [21:0] m_d, exp_q;
	logic [3:0] m_cs;
	logic [1:0] m_side;
	int bad_count = 0, total_checks = 0, cycles = 0, n;
	wire logic [21:0] d, qa, qb;
	wire logic [3:0] cs;
	wire logic [1:0] ke, te, c0, c1, ka, kb, ta, tb2;
	wire logic gt, par, fo, oe, fv, fs;
	wire logic [22:0] fd;
	rcb_ctrl_model ctl (.i_clk(i_clk), .i_nrst(i_nrst), .i_d(m_d), .i_cs_n(m_cs),
		.i_gate(m_gate), .i_side(m_side), .i_bad(m_bad), .o_d(d), .o_cs_n(cs),
		.o_gate(gt), .o_cke(ke), .o_odt(te), .o_par(par));
	rcb_buffer dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_gated_data_in(d),
		.i_chip_select_in0_n(cs[0]), .i_chip_select_in1_n(cs[1]),
		.i_chip_select_in2_n(cs[2]), .i_chip_select_in3_n(cs[3]),
		.i_select_gating_enable(gt), .i_clk_en_in(ke), .i_term_ctrl_in(te),
		.i_parity_bit_in(par), .o_gated_data_out_a(qa), .o_gated_data_out_b(qb),
		.o_select_copy_out0_n(c0), .o_select_copy_out1_n(c1), .o_clk_en_out_a(ka),
		.o_clk_en_out_b(kb), .o_term_ctrl_out_a(ta), .o_term_ctrl_out_b(tb2),
		.o_parity_fault_n_out(fo), .o_parity_fault_n_oe(oe), .o_fifo_valid(fv),
		.i_fifo_ready(i_fifo_ready), .o_fifo_data(fd), .o_fifo_in_stall(fs));
	// One command cycle, launched at a rising edge
	task automatic cyc(input logic [21:0] dv, input logic [3:0] c, input logic g,
		input logic b, input logic [1:0] s);
		@(posedge i_clk);
		m_d <= dv;
		m_cs <= c;
		m_gate <= g;
		m_bad <= b;
		m_side <= s;
		#1;
	endtask
	// Deselected cycle with gating on
	task automatic idle;
		cyc(22'h155555, 4'hf, 1'b1, 1'b0, 2'h0);
	endtask
	// Gated, select, clock enable and termination outputs low and fault line released
	task automatic chk_reset;
		`CHK("rst", 1'b0, |{qa, qb, c0, c1, ka, kb, ta, tb2, oe})
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Free-running clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 1000) begin
			bad_count++;
			report_and_stop;
		end
	end
	// Main sequence
	initial begin
		i_nrst = 1'b0;
		{m_d, m_cs, m_gate, m_bad, m_side, i_fifo_ready} = '0;
		exp_q = 22'h000000;
		repeat (6) @(posedge i_clk);
		chk_reset;
		`CHK("fo", 1'b0, fo)
		i_nrst <= 1'b1;
		repeat (4) idle;
		for (int i = 0; i < 6; i++) begin
			cyc(RD[i], RC[i], RG[i], RB[i], i[1:0]);
			for (int k = 1; k < 7; k++) begin
				idle;
				if (k == 1) begin
					if (RL[i]) exp_q = RD[i];
					`CHK("cs0", {2{RC[i][0]}}, c0)
					`CHK("cs1", {2{RC[i][1]}}, c1)
					`CHK("cke", {i[1:0], i[1:0]}, {ka, kb})
					`CHK("odt", {~i[1:0], ~i[1:0]}, {ta, tb2})
				end
				`CHK("qa", exp_q, qa)
				`CHK("qb", exp_q, qb)
				`CHK("oe", RE[i] && (k == 3 || k == 4), oe)
			end
		end
		// Overfill the trace buffer with consumer stalled, then drain
		repeat (14) cyc(22'h000000, 4'he, 1'b1, 1'b0, 2'h0);
		repeat (2) idle;
		`CHK("full", 1'b1, fs)
		@(posedge i_clk);
		i_fifo_ready <= 1'b1;
		n = 0;
		repeat (40) begin
			@(posedge i_clk);
			#1 n += (fv === 1'b1);
		end
		`CHK("pops", rcb_pkg::FIFO_D, n)
		`CHK("empty", 1'b0, fs)
		// Reset arriving mid-cycle while the fault line is pulled
		cyc(22'h000001, 4'he, 1'b1, 1'b1, 2'h3);
		repeat (4) idle;
		`CHK("oe", 1'b1, oe)
		#3 i_nrst = 1'b0;
		#1 chk_reset;
		@(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (3) begin
			idle;
			`CHK("quiet", 1'b0, oe)
		end
		report_and_stop;
	end
endmodule
